/* File: flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
package flash_tb_pkg;
  function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
endpackage

module flash_dev_model #(
  parameter logic [31:0] CFG_UNLOCK   = 32'h0000_00A5,
  parameter logic [31:0] FLASH_UNLOCK = 32'h0000_005A,
  parameter int          CNT_SHIFT    = 8
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [31:0] dev_addr_i,
  input  wire logic [31:0] dev_wdata_i,
  input  wire logic        dev_wr_i,
  input  wire logic        dev_rd_i,
  output logic      [31:0] dev_rdata_o,
  output logic             dev_ack_o
);
  logic [31:0] mem [0:32767];
  logic [31:0] pbuf [0:31];
  logic [31:0] ctrl, addr_r, w, rd;
  logic [8:0]  tmr;
  logic [15:0] crc;
  logic [4:0]  ptr;
  logic        cfg_open, fmode, busy;
  int          cnt, lim, dly;
  initial for (int k = 0; k < 32768; k++) mem[k] = k * 32'h9E37_79B9;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl = '0; addr_r = '0; tmr = 9'h0BB; crc = 16'hFFFF; ptr = '0;
      cfg_open = 0; fmode = 0; busy = 0; cnt = 0; lim = 0; dly = 0;
      dev_ack_o <= 1'b0;
      dev_rdata_o <= 32'h0000_0000;
    end else begin
      dev_ack_o <= 1'b0;
      dev_rdata_o <= ~dev_rdata_o;
      if (busy) cnt++;
      if (busy && cnt >= lim) busy = 0;
      if ((dev_wr_i || dev_rd_i) && !dev_ack_o) begin
        if (dly == 0) dly = 1 + $urandom % 4;
        dly--;
        if (dly == 0) begin
          dev_ack_o <= 1'b1;
          w = dev_wdata_i;
          if (dev_wr_i) begin
            case (dev_addr_i)
              flash_host_pkg::MODE_OFS: begin
                cfg_open = (w == CFG_UNLOCK);
                fmode = (w == FLASH_UNLOCK) || (fmode && w != 0);
              end
              flash_host_pkg::CTRL_OFS: begin
                if (w[0]) ptr = '0;
                if (w[4] && !ctrl[4] && w[5] && fmode && !busy) begin
                  if (w[2]) for (int k = 0; k < 32; k++) mem[15'(addr_r + k)] = pbuf[k];
                  if (w[1]) for (int k = 0; k < 32768; k++)
                    if (w[8] || k[14:5] == addr_r[14:5]) mem[k] = 32'hFFFF_FFFF;
                  busy = 1;
                  cnt = 0;
                  lim = {tmr, 8'hFF} >> CNT_SHIFT;
                end
                if (w[20] && !ctrl[20]) begin
                  busy = 1;
                  cnt = 0;
                  lim = {tmr, 8'hFF} >> CNT_SHIFT;
                end
                if (w[23]) crc = 16'hFFFF;
                ctrl = {cfg_open ? w[31:24] : ctrl[31:24], w[23:0]};
              end
              flash_host_pkg::ADDR_OFS:  addr_r = w;
              flash_host_pkg::WDATA_OFS: if (ctrl[3]) pbuf[ptr++] = w;
              flash_host_pkg::TIMER_OFS: tmr = w[8:0];
              default: ;
            endcase
          end else begin
            case (dev_addr_i)
              flash_host_pkg::MODE_OFS:  rd = {24'h0, !busy, 7'h0};
              flash_host_pkg::CTRL_OFS:  rd = ctrl;
              flash_host_pkg::TIMER_OFS: rd = {23'h0, tmr};
              flash_host_pkg::CRC_OFS:   rd = {16'h0, crc};
              default: begin
                rd = (fmode || ctrl[2]) ? ~dev_rdata_o : mem[dev_addr_i[16:2]];
                if (ctrl[22]) crc = flash_tb_pkg::crc16_word(crc, rd);
              end
            endcase
            dev_rdata_o <= rd;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: flash_host_pkg.sv */
package flash_host_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Device register map (byte addresses)
  localparam logic [31:0] FLASH_BASE   = 32'h0000_0000;
  localparam logic [31:0] MODE_OFS     = 32'h0000_0100;
  localparam logic [31:0] CTRL_OFS     = 32'h0000_0104;
  localparam logic [31:0] ADDR_OFS     = 32'h0000_010C;
  localparam logic [31:0] WDATA_OFS    = 32'h0000_0110;
  localparam logic [31:0] TIMER_OFS    = 32'h0000_0114;
  localparam logic [31:0] DIRTY_OFS    = 32'h0000_0118;
  localparam logic [31:0] CRC_OFS      = 32'h0000_0120;

  //////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam logic [31:0] BUFFER_CLEAR_BIT  = 32'h0000_0001;
  localparam logic [31:0] ERASE_BIT         = 32'h0000_0002;
  localparam logic [31:0] PROGRAM_BIT       = 32'h0000_0004;
  localparam logic [31:0] BUFFER_LOAD_BIT   = 32'h0000_0008;
  localparam logic [31:0] WRITE_EN_BIT      = 32'h0000_0010;
  localparam logic [31:0] PROGRAM_MODE_BIT  = 32'h0000_0020;
  localparam logic [31:0] BULK_ERASE_BIT    = 32'h0000_0100;
  localparam logic [31:0] TIMER_BIT         = 32'h0010_0000;
  localparam logic [31:0] CHECKSUM_EN_BIT   = 32'h0040_0000;
  localparam logic [31:0] CHECKSUM_INIT_BIT = 32'h0080_0000;
  localparam int          UPPER_LSB         = 24;
  localparam int          IDLE_POS          = 7;
  localparam logic [31:0] LOCK_VALUE        = 32'h0000_0000;
  localparam logic [31:0] DIRTY_CLEAR_VALUE = 32'h0000_0000;
  localparam logic [31:0] TMR_CLOSE_VALUE   = 32'h0000_09C4;

  //////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_COUNT = 1024;
  localparam int PAGE_WORDS = PAGE_BYTES / 4;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer entry points
  localparam logic [5:0] ERASE_ENTRY = 6'h1C;
  localparam logic [5:0] CLOSE_ENTRY = 6'h12;
  localparam logic [5:0] CRC_ENTRY   = 6'h28;

  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_BULK, OP_CRC} op_t;

  typedef enum logic [3:0] {
    K_WR, K_CRSET, K_CRCLR, K_CRUP, K_CRREST, K_WAIT, K_PAGE, K_ADDR,
    K_AESEL, K_BRANCH, K_GOTO, K_CRCRD, K_CRCGET, K_END
  } step_kind_t;

  typedef struct packed {
    step_kind_t  kind;
    logic [31:0] addr;
    logic [31:0] data;
  } step_t;

endpackage

/* File: flash_program_erase_controller.sv */
// Notes on behaviour
// - Program and erase only in flash mode; this host runs outside the array.
// - Upper control bits need the configuration unlock first.
// - Writing zero to the mode register locks; lock after each session.
// - Select response setting and four-cycle access before program or erase.
// - Watchdog held and internal oscillator selected during the operation.
// - Enter: flash unlock, clear dirty, set program mode, wait idle.
// - Page: buffer clear pulse, load, words, unload, address, program, enable, wait.
// - Page target in the address register is in 32-bit word units.
// - Erase: bulk bit or address, erase bit, enable, wait, clear all three.
// - Close: load 2500 into timer, timer bit, wait, clear, leave program mode.
// - Interrupts blocked while program or erase runs.
// - Buffer load sits at control bit 3, buffer clear at bit 0.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_controller #(
  parameter logic [31:0] CFG_UNLOCK   = 32'h0000_00A5,
  parameter logic [31:0] FLASH_UNLOCK = 32'h0000_005A,
  parameter logic [7:0]  UPPER_CFG    = 8'h03
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [31:0] cmd_addr_i,
  input  wire logic [15:0] cmd_len_i,
  input  wire logic [7:0]  restore_upper_i,
  output logic             cmd_ready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wdata_valid_i,
  output logic             wdata_ready_o,
  output logic             done_o,
  output logic             busy_o,
  output logic [15:0]      crc_o,
  output logic             wdt_hold_o,
  output logic             osc_int_sel_o,
  output logic             irq_block_o,
  output logic [31:0]      dev_addr_o,
  output logic [31:0]      dev_wdata_o,
  output logic             dev_wr_o,
  output logic             dev_rd_o,
  input  wire logic [31:0] dev_rdata_i,
  input  wire logic        dev_ack_i
);

  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_BUS} phase_t;

  typedef struct packed {
    phase_t                  phase;
    flash_host_pkg::op_t     op;
    logic [5:0]              pc;
    logic [31:0]             cr;
    logic [31:0]             addr;
    logic [15:0]             len;
    logic [15:0]             cnt;
    logic [7:0]              restore;
    logic [15:0]             crc;
    logic                    done;
    logic                    req;
    logic                    wr;
    logic [31:0]             raddr;
    logic [31:0]             rdata;
  } host_state_t;

  host_state_t           st;
  host_state_t           next_st;
  flash_host_pkg::step_t stp;
  logic                  adv;

  reg_req_if bus ();

  //////////////////////////////////////////////////////////////////////////////
  // Step table
  function automatic flash_host_pkg::step_t mk(input flash_host_pkg::step_kind_t k,
                                               input logic [31:0] a, input logic [31:0] d);
    mk = '{kind: k, addr: a, data: d};
  endfunction

  function automatic flash_host_pkg::step_t step_f(input logic [5:0] pc);
    unique case (pc)
      6'h00: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, CFG_UNLOCK);
      6'h01: step_f = mk(flash_host_pkg::K_CRUP, flash_host_pkg::CTRL_OFS, '0);
      6'h02: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, flash_host_pkg::LOCK_VALUE);
      6'h03: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, FLASH_UNLOCK);
      6'h04: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::DIRTY_OFS, flash_host_pkg::DIRTY_CLEAR_VALUE);
      6'h05: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::PROGRAM_MODE_BIT);
      6'h06: step_f = mk(flash_host_pkg::K_WAIT, flash_host_pkg::MODE_OFS, '0);
      6'h07: step_f = mk(flash_host_pkg::K_BRANCH, '0, {26'h0, flash_host_pkg::ERASE_ENTRY});
      6'h08: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::BUFFER_CLEAR_BIT);
      6'h09: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::BUFFER_CLEAR_BIT);
      6'h0A: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::BUFFER_LOAD_BIT);
      6'h0B: step_f = mk(flash_host_pkg::K_PAGE, flash_host_pkg::WDATA_OFS, '0);
      6'h0C: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::BUFFER_LOAD_BIT);
      6'h0D: step_f = mk(flash_host_pkg::K_ADDR, flash_host_pkg::ADDR_OFS, '0);
      6'h0E: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::PROGRAM_BIT);
      6'h0F: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::WRITE_EN_BIT);
      6'h10: step_f = mk(flash_host_pkg::K_WAIT, flash_host_pkg::MODE_OFS, '0);
      6'h11: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS,
                         flash_host_pkg::WRITE_EN_BIT | flash_host_pkg::PROGRAM_BIT);
      6'h12: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::TIMER_OFS, flash_host_pkg::TMR_CLOSE_VALUE);
      6'h13: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::TIMER_BIT);
      6'h14: step_f = mk(flash_host_pkg::K_WAIT, flash_host_pkg::MODE_OFS, '0);
      6'h15: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::TIMER_BIT);
      6'h16: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::PROGRAM_MODE_BIT);
      6'h17: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, flash_host_pkg::LOCK_VALUE);
      6'h18: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, CFG_UNLOCK);
      6'h19: step_f = mk(flash_host_pkg::K_CRREST, flash_host_pkg::CTRL_OFS, '0);
      6'h1A: step_f = mk(flash_host_pkg::K_WR, flash_host_pkg::MODE_OFS, flash_host_pkg::LOCK_VALUE);
      6'h1C: step_f = mk(flash_host_pkg::K_AESEL, flash_host_pkg::ADDR_OFS, '0);
      6'h1D: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::ERASE_BIT);
      6'h1E: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS, flash_host_pkg::WRITE_EN_BIT);
      6'h1F: step_f = mk(flash_host_pkg::K_WAIT, flash_host_pkg::MODE_OFS, '0);
      6'h20: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::WRITE_EN_BIT |
                         flash_host_pkg::ERASE_BIT | flash_host_pkg::BULK_ERASE_BIT);
      6'h21: step_f = mk(flash_host_pkg::K_GOTO, '0, {26'h0, flash_host_pkg::CLOSE_ENTRY});
      6'h28: step_f = mk(flash_host_pkg::K_CRSET, flash_host_pkg::CTRL_OFS,
                         flash_host_pkg::CHECKSUM_EN_BIT | flash_host_pkg::CHECKSUM_INIT_BIT);
      6'h29: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::CHECKSUM_INIT_BIT);
      6'h2A: step_f = mk(flash_host_pkg::K_CRCRD, flash_host_pkg::FLASH_BASE, '0);
      6'h2B: step_f = mk(flash_host_pkg::K_CRCGET, flash_host_pkg::CRC_OFS, '0);
      6'h2C: step_f = mk(flash_host_pkg::K_CRCLR, flash_host_pkg::CTRL_OFS, flash_host_pkg::CHECKSUM_EN_BIT);
      default: step_f = mk(flash_host_pkg::K_END, '0, '0);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    stp          = step_f(st.pc);
    adv          = 1'b0;
    next_st      = st;
    next_st.req  = 1'b0;
    next_st.done = 1'b0;
    unique case (st.phase)
      PH_IDLE: begin
        if (cmd_valid_i) begin
          next_st.phase   = PH_RUN;
          next_st.op      = flash_host_pkg::op_t'(cmd_op_i);
          next_st.addr    = cmd_addr_i;
          next_st.len     = cmd_len_i;
          next_st.restore = restore_upper_i;
          next_st.cnt     = '0;
          next_st.pc      = (cmd_op_i == 2'(flash_host_pkg::OP_CRC)) ? flash_host_pkg::CRC_ENTRY : 6'h00;
        end
      end
      PH_RUN: begin
        next_st.raddr = stp.addr;
        next_st.wr    = 1'b1;
        next_st.rdata = st.cr;
        next_st.req   = 1'b1;
        next_st.phase = PH_BUS;
        unique case (stp.kind)
          flash_host_pkg::K_WR: next_st.rdata = stp.data;
          flash_host_pkg::K_CRSET: next_st.cr = st.cr | stp.data;
          flash_host_pkg::K_CRCLR: next_st.cr = st.cr & ~stp.data;
          flash_host_pkg::K_CRUP: next_st.cr[31:flash_host_pkg::UPPER_LSB] = UPPER_CFG;
          flash_host_pkg::K_CRREST: next_st.cr[31:flash_host_pkg::UPPER_LSB] = st.restore;
          flash_host_pkg::K_WAIT: next_st.wr = 1'b0;
          flash_host_pkg::K_PAGE: begin
            next_st.rdata = wdata_i;
            if (!wdata_valid_i) begin
              next_st.req   = 1'b0;
              next_st.phase = PH_RUN;
            end
          end
          flash_host_pkg::K_ADDR: next_st.rdata = st.addr;
          flash_host_pkg::K_AESEL: begin
            if (st.op == flash_host_pkg::OP_BULK) begin
              next_st.raddr = flash_host_pkg::CTRL_OFS;
              next_st.cr    = st.cr | flash_host_pkg::BULK_ERASE_BIT;
            end else begin
              next_st.rdata = st.addr;
            end
          end
          flash_host_pkg::K_BRANCH: begin
            next_st.req   = 1'b0;
            next_st.phase = PH_RUN;
            next_st.pc    = (st.op == flash_host_pkg::OP_PROG) ? st.pc + 6'd1 : stp.data[5:0];
          end
          flash_host_pkg::K_GOTO: begin
            next_st.req   = 1'b0;
            next_st.phase = PH_RUN;
            next_st.pc    = stp.data[5:0];
          end
          flash_host_pkg::K_CRCRD: begin
            next_st.wr    = 1'b0;
            next_st.raddr = stp.addr + st.addr + {14'h0, st.cnt, 2'b00};
          end
          flash_host_pkg::K_CRCGET: next_st.wr = 1'b0;
          flash_host_pkg::K_END: begin
            next_st.req   = 1'b0;
            next_st.done  = 1'b1;
            next_st.phase = PH_IDLE;
          end
        endcase
        if (next_st.raddr == flash_host_pkg::CTRL_OFS && next_st.wr) begin
          next_st.rdata = next_st.cr;
        end
      end
      PH_BUS: begin
        if (bus.done) begin
          next_st.phase = PH_RUN;
          unique case (stp.kind)
            flash_host_pkg::K_WAIT: adv = bus.rdata[flash_host_pkg::IDLE_POS];
            flash_host_pkg::K_PAGE: adv = (st.cnt == 16'(flash_host_pkg::PAGE_WORDS - 1));
            flash_host_pkg::K_CRCRD: adv = (st.cnt + 16'd1 >= st.len);
            flash_host_pkg::K_CRCGET: begin
              next_st.crc = bus.rdata[15:0];
              adv         = 1'b1;
            end
            default: adv = 1'b1;
          endcase
          if (adv) begin
            next_st.pc  = st.pc + 6'd1;
            next_st.cnt = '0;
          end else if (stp.kind != flash_host_pkg::K_WAIT) begin
            next_st.cnt = st.cnt + 16'd1;
          end
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register access engine
  assign bus.req   = st.req;
  assign bus.wr    = st.wr;
  assign bus.addr  = st.raddr;
  assign bus.wdata = st.rdata;

  reg_access_port u_port (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .link        (bus.port),
    .dev_addr_o  (dev_addr_o),
    .dev_wdata_o (dev_wdata_o),
    .dev_wr_o    (dev_wr_o),
    .dev_rd_o    (dev_rd_o),
    .dev_rdata_i (dev_rdata_i),
    .dev_ack_i   (dev_ack_i)
  );

  //////////////////////////////////////////////////////////////////////////////
  // User side
  assign cmd_ready_o   = (st.phase == PH_IDLE);
  assign wdata_ready_o = (st.phase == PH_RUN) && (stp.kind == flash_host_pkg::K_PAGE);
  assign done_o        = st.done;
  assign busy_o        = (st.phase != PH_IDLE);
  assign crc_o         = st.crc;
  assign wdt_hold_o    = busy_o && (st.op != flash_host_pkg::OP_CRC);
  assign osc_int_sel_o = busy_o && (st.op != flash_host_pkg::OP_CRC);
  assign irq_block_o   = busy_o && (st.op != flash_host_pkg::OP_CRC);

endmodule
`default_nettype wire

/* File: flash_program_erase_controller_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_controller_properties (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        cmd_valid_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        busy_o,
  input wire logic        wdata_ready_o,
  input wire logic        wdt_hold_o,
  input wire logic        osc_int_sel_o,
  input wire logic        irq_block_o,
  input wire logic [31:0] dev_addr_o,
  input wire logic [31:0] dev_wdata_o,
  input wire logic        dev_wr_o,
  input wire logic        dev_rd_o,
  input wire logic        dev_ack_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic ctrl_wr;
  assign ctrl_wr = dev_wr_o && dev_addr_o == flash_host_pkg::CTRL_OFS;

  a_req_held: assert property ((dev_wr_o || dev_rd_o) && !dev_ack_i |=> (dev_wr_o || dev_rd_o) &&
    $stable(dev_addr_o) && $stable(dev_wdata_o)) else $error("device request changed before ack");
  a_strobe_drop: assert property ((dev_wr_o || dev_rd_o) && dev_ack_i |=> !dev_wr_o && !dev_rd_o)
    else $error("strobe held after ack");
  a_one_strobe: assert property (!(dev_wr_o && dev_rd_o)) else $error("read and write together");
  a_done_pulse: assert property (done_o |-> (!busy_o && cmd_ready_o) ##1 !done_o)
    else $error("done not a single pulse ending busy");
  a_take_busy: assert property (cmd_valid_i && cmd_ready_o |=> busy_o && !cmd_ready_o)
    else $error("command not taken");
  a_we_program_mode_bit: assert property (ctrl_wr && dev_wdata_o[4] |-> dev_wdata_o[5])
    else $error("write enable outside program mode");
  a_we_guard: assert property (ctrl_wr && dev_wdata_o[4] |-> wdt_hold_o && osc_int_sel_o && irq_block_o)
    else $error("operation without system guards");
  a_load_guard: assert property (wdata_ready_o |-> busy_o && wdt_hold_o)
    else $error("page word wanted outside program");
  a_init_clear: assert property (ctrl_wr && dev_wdata_o[23] && dev_ack_i |->
    ##[2:20] (ctrl_wr && !dev_wdata_o[23])) else $error("checksum init not cleared");
endmodule
bind flash_program_erase_controller flash_program_erase_controller_properties i_props (.*);
`default_nettype wire

/* File: reg_access_port.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_access_port (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  reg_req_if.port          link,
  output logic [31:0]      dev_addr_o,
  output logic [31:0]      dev_wdata_o,
  output logic             dev_wr_o,
  output logic             dev_rd_o,
  input  wire logic [31:0] dev_rdata_i,
  input  wire logic        dev_ack_i
);

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;

  //////////////////////////////////////////////////////////////////////////////
  // One access at a time, held until the device acknowledges
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.wr || st.rd) begin
      if (dev_ack_i) begin
        next_st.wr    = 1'b0;
        next_st.rd    = 1'b0;
        next_st.done  = 1'b1;
        next_st.rdata = st.rd ? dev_rdata_i : st.rdata;
      end
    end else if (link.req) begin
      next_st.wr    = link.wr;
      next_st.rd    = !link.wr;
      next_st.addr  = link.addr;
      next_st.wdata = link.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dev_addr_o  = st.addr;
  assign dev_wdata_o = st.wdata;
  assign dev_wr_o    = st.wr;
  assign dev_rd_o    = st.rd;
  assign link.done   = st.done;
  assign link.rdata  = st.rdata;

endmodule
`default_nettype wire

/* File: reg_req_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface reg_req_if;
  logic        req;
  logic        wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;

  modport master (output req, wr, addr, wdata, input done, rdata);
  modport port   (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* File: test_flash_program_erase_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module test_flash_program_erase_controller;
  typedef struct {logic [1:0] op; logic [31:0] addr; logic [15:0] crc;} note_t;
  logic ref_clk_i = 0, nrst_i, cmd_valid_i, wdata_valid_i, cmd_ready_o, wdata_ready_o, done_o, busy_o;
  logic wdt_hold_o, osc_int_sel_o, irq_block_o, dev_wr_o, dev_rd_o, dev_ack_i;
  logic [1:0]  cmd_op_i;
  logic [31:0] cmd_addr_i, wdata_i, dev_addr_o, dev_wdata_o, dev_rdata_i, p, pg [0:31];
  logic [15:0] cmd_len_i, crc_o, c;
  logic [7:0]  restore_upper_i;
  note_t       q[$];
  note_t       n;
  int          n_errors = 0, n_tests = 0, cnt;

  always #12.5 ref_clk_i = ~ref_clk_i;

  flash_program_erase_controller i_flash_program_erase_controller (.*);
  flash_dev_model #(.CFG_UNLOCK(32'h0000_00A5), .FLASH_UNLOCK(32'h0000_005A), .CNT_SHIFT(8))
    i_flash_dev_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .dev_addr_i(dev_addr_o),
    .dev_wdata_i(dev_wdata_o), .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o), .dev_rdata_o(dev_rdata_i),
    .dev_ack_o(dev_ack_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic run(input logic [1:0] op, input logic [31:0] a, input logic [15:0] len, input logic [15:0] ec);
    int k;
    k = 0;
    q.push_back('{op, a, ec});
    @(negedge ref_clk_i);
    cmd_valid_i = 1;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_len_i = len;
    if (op != 2'd3) restore_upper_i = 8'($urandom);
    @(negedge ref_clk_i);
    cmd_op_i = 2'd3;
    fork
      begin
        repeat (4) @(negedge ref_clk_i);
        cmd_valid_i = 0;
      end
      while (op == 2'd0 && k < 32) begin
        @(negedge ref_clk_i);
        wdata_i = pg[k];
        wdata_valid_i = ($urandom % 3) != 0;
        if (wdata_valid_i && wdata_ready_o) k++;
      end
    join
    @(negedge ref_clk_i);
    wdata_valid_i = 0;
    wait (q.size() == 0);
    @(negedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk_i) begin
    if (nrst_i && done_o === 1'b1) begin
      if (q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        n = q.pop_front();
        `CHK(i_flash_dev_model.cfg_open, 1'b0)
        `CHK(i_flash_dev_model.ctrl[31:24], restore_upper_i)
        case (n.op)
          2'd0: for (int k = 0; k < 32; k++) `CHK(i_flash_dev_model.mem[15'(n.addr + k)], pg[k])
          2'd1: for (int k = 0; k < 32; k++) `CHK(i_flash_dev_model.mem[15'(n.addr + k)], 32'hFFFF_FFFF)
          2'd2: begin
            cnt = 0;
            for (int k = 0; k < 32768; k++) if (i_flash_dev_model.mem[k] !== 32'hFFFF_FFFF) cnt++;
            `CHK(cnt, 0)
          end
          default: `CHK(crc_o, n.crc)
        endcase
      end
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_errors++;
    $display("[FAIL] %0t timeout", $time);
    print_verdict();
  end

  initial begin
    nrst_i = 0;
    {cmd_valid_i, wdata_valid_i, cmd_op_i, cmd_addr_i, cmd_len_i, restore_upper_i, wdata_i} = '0;
    void'($urandom(69148));
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    nrst_i = 1;
    `CHK({cmd_ready_o, busy_o, done_o, dev_wr_o, dev_rd_o, crc_o}, {2'b10, 3'b000, 16'h0000})
    p = 32'd4 + $urandom % 1000;
    c = 16'hFFFF;
    foreach (pg[k]) pg[k] = $urandom;
    foreach (pg[k]) c = flash_tb_pkg::crc16_word(c, pg[k]);
    run(2'd0, p * 32, 16'h0000, 16'h0000);
    run(2'd3, p * 128, 16'h0020, c);
    run(2'd1, p * 32, 16'h0000, 16'h0000);
    c = 16'hFFFF;
    repeat (32) c = flash_tb_pkg::crc16_word(c, 32'hFFFF_FFFF);
    run(2'd3, p * 128, 16'h0020, c);
    run(2'd2, 32'h0000_0000, 16'h0000, 16'h0000);
    run(2'd3, 32'h0000_0400, 16'h0000, flash_tb_pkg::crc16_word(16'hFFFF, 32'hFFFF_FFFF));
    `CHK(q.size(), 0)
    print_verdict();
  end
endmodule
`default_nettype wire
